// file: core/adc_mode_decoder.sv
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "adc_mode_map.svh"
// How it works
// - Bit 0 high with bits 4-7 high enters test mode; bits 1-3 ignored.
// - In test mode all channel pins are actively driven outputs.
// - Power cycle (reset) returns user mode and resynchronizes the serial link.
// - Status read reports bit 9 high in test mode, low in user mode.
// - Reset, two test-mode words, then user-mode word returns to user mode.
// - Recovery encodings: reset, two test-mode words and user word are fixed.
// - Power-up word and set-sign word with bit 0 choosing sign are decoded.
// - Set-acquisition word uses bits 0-1 for acquisition length.
// - Conversion pin high during transfer reads old result, no new conversion.
// - Differential: even channels to output one, odd to output two, fixed pairs.
// - Differential: either converter input may take positive polarity.
// - Single ended: any channel to output one, zero reference to output two.
// - Result is two's complement -4095..4095, negative when negative input larger.
// - Single ended results always have the sign bit low.
module adc_mode_decoder (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic serial_instruction_in_i,
  input wire logic conv_n_i,
  output logic serial_data_o,
  input wire logic [7:0] analog_channel_pins_i,
  output logic [7:0] analog_channel_pins_o,
  output logic [7:0] analog_channel_pins_oe_o,
  input wire logic [95:0] chan_level_i,
  input wire logic [11:0] zero_reference_input_i,
  output logic [11:0] mux_output_one_o,
  output logic [11:0] mux_output_two_o,
  output logic test_mode_o
);
  adc_mode_pkg::recovery_step_t step;
  adc_mode_pkg::code_t result, conv_code;
  adc_mode_pkg::level_t mux_one, mux_two;
  logic test_mode, sign_on, wide, powered, show_status;
  logic [1:0] acq;
  logic [7:0] conv_cfg, instr, test_pattern;
  logic [7:0] pins_meta, pins_q;
  logic [95:0] lvl_meta, lvl_q;
  logic [11:0] zref_meta, zref_q;
  logic conv_meta, conv_q, conv_d, conv_high_seen;
  logic frame_done, frame_active, link_dout;
  logic [4:0] word_len;
  logic [16:0] out_word;
  logic [16:0] status_word;
  logic is_conv, is_test, is_sign, is_acq, is_status;

  function automatic logic hit(input logic [7:0] ins, input logic [7:0] mask,
                               input logic [7:0] val);
    hit = (ins & mask) == val;
  endfunction

  // Conversion-pin, channel-pin and level inputs come from outside the clock domain
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_meta <= 1'b1;
      conv_q <= 1'b1;
      conv_d <= 1'b1;
      pins_meta <= 8'h00;
      pins_q <= 8'h00;
      lvl_meta <= 96'h0;
      lvl_q <= 96'h0;
      zref_meta <= 12'h000;
      zref_q <= 12'h000;
    end else begin
      conv_meta <= conv_n_i;
      conv_q <= conv_meta;
      // One more stage lines the pin up with the registered frame flag
      conv_d <= conv_q;
      pins_meta <= analog_channel_pins_i;
      pins_q <= pins_meta;
      lvl_meta <= chan_level_i;
      lvl_q <= lvl_meta;
      zref_meta <= zero_reference_input_i;
      zref_q <= zref_meta;
    end
  end

  serial_link u_link (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .serial_instruction_in_i(serial_instruction_in_i),
    .word_len_i(word_len),
    .load_word_i(out_word),
    .frame_done_o(frame_done),
    .instr_o(instr),
    .frame_active_o(frame_active),
    .serial_data_o(link_dout)
  );

  channel_router u_router (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .chan_level_i(lvl_q),
    .zero_reference_input_i(zref_q),
    .cfg_i(instr),
    .mux_output_one_o(mux_one),
    .mux_output_two_o(mux_two),
    .result_o(conv_code)
  );

  assign is_test = hit(instr, `INS_TEST_MASK, `INS_TEST_VAL);
  assign is_conv = hit(instr, `INS_CONV_MASK, `INS_CONV_VAL);
  assign is_sign = hit(instr, `INS_SIGN_MASK, `INS_SIGN_VAL);
  assign is_acq = hit(instr, `INS_ACQ_MASK, `INS_ACQ_VAL);
  assign is_status = hit(instr, `INS_ALL_MASK, `INS_STATUS_VAL);

  // A conversion-pin high anywhere in the transfer makes it a read only
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_high_seen <= 1'b0;
    end else if (frame_active && conv_d) begin
      conv_high_seen <= 1'b1;
    end else if (frame_done) begin
      conv_high_seen <= 1'b0;
    end
  end

  // Mode and recovery sequence; reset is the power cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_mode <= 1'b0;
      step <= adc_mode_pkg::REC_IDLE;
    end else if (frame_done) begin
      if (!test_mode) begin
        step <= adc_mode_pkg::REC_IDLE;
        if (is_test) begin
          test_mode <= 1'b1;
        end
      end else if (hit(instr, `INS_ALL_MASK, `INS_RESET_VAL)) begin
        step <= adc_mode_pkg::REC_GOT_RESET;
      end else begin
        case (step)
          adc_mode_pkg::REC_GOT_RESET: begin
            step <= hit(instr, `INS_ALL_MASK, `INS_TEST_A_VAL) ?
                    adc_mode_pkg::REC_GOT_FIRST : adc_mode_pkg::REC_IDLE;
          end
          adc_mode_pkg::REC_GOT_FIRST: begin
            step <= hit(instr, `INS_ALL_MASK, `INS_TEST_B_VAL) ?
                    adc_mode_pkg::REC_GOT_SECOND : adc_mode_pkg::REC_IDLE;
          end
          adc_mode_pkg::REC_GOT_SECOND: begin
            step <= adc_mode_pkg::REC_IDLE;
            if (hit(instr, `INS_ALL_MASK, `INS_USER_VAL)) begin
              test_mode <= 1'b0;
            end
          end
          default: begin
            step <= adc_mode_pkg::REC_IDLE;
          end
        endcase
      end
    end
  end

  // Configuration words; in test mode only recovery and status are honoured
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sign_on <= 1'b1;
      wide <= 1'b0;
      acq <= 2'b00;
      powered <= 1'b1;
      show_status <= 1'b0;
    end else if (frame_done) begin
      show_status <= is_status;
      if (!test_mode) begin
        if (hit(instr, `INS_ALL_MASK, `INS_POWER_UP_VAL)) begin
          powered <= 1'b1;
        end
        if (is_sign) begin
          sign_on <= instr[0];
        end
        if (is_acq) begin
          acq <= instr[1:0];
        end
        // Format only follows a conversion that really starts
        if (is_conv && !conv_high_seen) begin
          wide <= instr[`CF_WIDE];
        end
      end
    end
  end

  // Conversion result, muxing kept from the last started conversion
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result <= 13'h0000;
      conv_cfg <= 8'h00;
      mux_output_one_o <= 12'h000;
      mux_output_two_o <= 12'h000;
    end else if (frame_done && !test_mode && is_conv && !conv_high_seen) begin
      result <= conv_code;
      conv_cfg <= instr;
      mux_output_one_o <= mux_one;
      mux_output_two_o <= mux_two;
    end
  end

  assign word_len = (wide ? `LEN_WIDE : `LEN_NARROW) + {4'h0, sign_on};
  always_comb begin
    status_word = 17'h00000;
    status_word[`ST_SIGN] = sign_on;
    status_word[`ST_ACQ_LSB +: 2] = acq;
    status_word[`ST_WIDE] = wide;
    status_word[`ST_POWERED] = powered;
    status_word[`ST_TEST] = test_mode;
  end
  // Word left justified so the first bit out is the word's top bit
  assign out_word = show_status ? status_word :
                    17'({{4{result[`SIGN_BIT]}}, result} << (`WORD_BITS - word_len));

  // Channel pins turn into driven outputs in test mode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_channel_pins_oe_o <= 8'h00;
      analog_channel_pins_o <= 8'h00;
      test_mode_o <= 1'b0;
      serial_data_o <= 1'b0;
    end else begin
      analog_channel_pins_oe_o <= {8{test_mode}};
      analog_channel_pins_o <= test_pattern;
      test_mode_o <= test_mode;
      serial_data_o <= link_dout;
    end
  end

  // Wishbone slave, one wait state, unmapped reads return zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      test_pattern <= `CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
          test_pattern <= wb_dat_i[7:0];
        end
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {24'h000000, test_pattern};
          `REG_STATUS: wb_dat_o <= {pins_q, 7'h00, status_word};
          `REG_RESULT: wb_dat_o <= {11'h000, conv_cfg, result};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  sequence s_user_ins;
    frame_done && hit(instr, `INS_ALL_MASK, `INS_USER_VAL);
  endsequence
  sequence s_reset_ins;
    frame_done && test_mode && hit(instr, `INS_ALL_MASK, `INS_RESET_VAL);
  endsequence

  AST_TEST_ENTRY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && is_test) |=> test_mode) else $error("test instruction did not enter test mode");
  AST_PINS_DRIVEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    test_mode ##1 test_mode |-> analog_channel_pins_oe_o == 8'hFF)
    else $error("channel pins not driven in test mode");
  AST_POWER_USER: assert property (@(posedge clk_sys_i)
    !rst_n_i |-> !test_mode && step == adc_mode_pkg::REC_IDLE) else $error("reset left test mode");
  AST_STATUS_BIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && is_status) |=> show_status && out_word[`ST_TEST] == test_mode)
    else $error("status bit 9 wrong");
  AST_RECOVERY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (step == adc_mode_pkg::REC_GOT_SECOND && test_mode) ##0 s_user_ins |=> !test_mode)
    else $error("recovery sequence did not leave test mode");
  AST_RESET_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_reset_ins |=> step == adc_mode_pkg::REC_GOT_RESET) else $error("reset word not tracked");
  AST_SIGN_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && !test_mode && is_sign) |=> sign_on == $past(instr[0]))
    else $error("sign option not taken");
  AST_ACQ_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && !test_mode && is_acq) |=> acq == $past(instr[1:0]))
    else $error("acquisition length not taken");
  AST_READ_ONLY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_done && conv_high_seen) |=> $stable(result)) else $error("conversion started while pin high");
endmodule

// file: core/channel_router.sv
`timescale 1ns/1ps
`include "adc_mode_map.svh"
module channel_router (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [95:0] chan_level_i,
  input wire logic [11:0] zero_reference_input_i,
  input wire logic [7:0] cfg_i,
  output adc_mode_pkg::level_t mux_output_one_o,
  output adc_mode_pkg::level_t mux_output_two_o,
  output adc_mode_pkg::code_t result_o
);
  adc_mode_pkg::level_t pos, neg;
  logic single;
  logic [2:0] chan;

  function automatic adc_mode_pkg::level_t pick(input logic [95:0] flat, input logic [2:0] idx);
    pick = flat[{idx, 2'b00} * 3 +: 12];
  endfunction

  assign single = cfg_i[`CF_SINGLE];
  assign chan = cfg_i[`CF_CHAN_LSB +: 3];

  always_comb begin
    if (single) begin
      mux_output_one_o = pick(chan_level_i, chan);
      mux_output_two_o = zero_reference_input_i;
    end else begin
      mux_output_one_o = pick(chan_level_i, {chan[2:1], 1'b0});
      mux_output_two_o = pick(chan_level_i, {chan[2:1], 1'b1});
    end
    // Single ended always takes input one as positive
    if (!single && cfg_i[`CF_SWAP]) begin
      pos = mux_output_two_o;
      neg = mux_output_one_o;
    end else begin
      pos = mux_output_one_o;
      neg = mux_output_two_o;
    end
    result_o = 13'({1'b0, pos} - {1'b0, neg});
    if (single && result_o[`SIGN_BIT]) begin
      result_o = 13'h0000;
    end
  end

  AST_SE_SIGN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    single |-> !result_o[`SIGN_BIT]) else $error("single ended result negative");
  AST_DIFF_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !single |-> mux_output_one_o == chan_level_i[{chan[2:1], 3'b000} * 3 +: 12])
    else $error("differential even channel not on output one");
  AST_SIGN_TRACKS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (!single && neg > pos) |-> result_o[`SIGN_BIT]) else $error("negative input not negative");
endmodule

// file: core/serial_link.sv
`timescale 1ns/1ps
`include "adc_mode_map.svh"
module serial_link (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic serial_instruction_in_i,
  input wire logic [4:0] word_len_i,
  input wire logic [16:0] load_word_i,
  output logic frame_done_o,
  output logic [7:0] instr_o,
  output logic frame_active_o,
  output logic serial_data_o
);
  logic cs_meta, cs_q, cs_prev;
  logic sclk_meta, sclk_q, sclk_prev;
  logic di_meta, di_q;
  logic [4:0] cnt;
  logic [7:0] instr_sh;
  logic [16:0] out_sh;
  logic reload;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, last_bit, done;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_meta <= 1'b1;
      cs_q <= 1'b1;
      cs_prev <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_q <= 1'b0;
      sclk_prev <= 1'b0;
      di_meta <= 1'b0;
      di_q <= 1'b0;
    end else begin
      cs_meta <= cs_n_i;
      cs_q <= cs_meta;
      cs_prev <= cs_q;
      sclk_meta <= sclk_i;
      sclk_q <= sclk_meta;
      sclk_prev <= sclk_q;
      di_meta <= serial_instruction_in_i;
      di_q <= di_meta;
    end
  end

  assign sclk_rise = sclk_q && !sclk_prev;
  assign sclk_fall = !sclk_q && sclk_prev;
  assign cs_fall = cs_prev && !cs_q;
  assign cs_rise = !cs_prev && cs_q;
  // With select held low the word length alone frames a transfer
  assign last_bit = !cs_q && sclk_rise && (cnt + 5'h01 == word_len_i);
  assign done = (cs_rise && cnt >= `INSTR_BITS) || last_bit;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 5'h00;
      instr_sh <= 8'h00;
    end else if (cs_q || last_bit) begin
      cnt <= 5'h00;
      if (last_bit && cnt < `INSTR_BITS) begin
        instr_sh[cnt[2:0]] <= di_q;
      end
    end else if (sclk_rise) begin
      cnt <= cnt + 5'h01;
      if (cnt < `INSTR_BITS) begin
        instr_sh[cnt[2:0]] <= di_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_done_o <= 1'b0;
      instr_o <= 8'h00;
      reload <= 1'b0;
    end else begin
      frame_done_o <= done;
      reload <= frame_done_o && !cs_q;
      if (done) begin
        instr_o <= instr_sh;
      end
    end
  end

  // Reload waits two cycles so the word reflects the decoded frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_sh <= 17'h00000;
      serial_data_o <= 1'b0;
      frame_active_o <= 1'b0;
    end else begin
      frame_active_o <= !cs_q;
      serial_data_o <= out_sh[`WORD_MSB];
      if (cs_fall || reload) begin
        out_sh <= load_word_i;
      end else if (sclk_fall && !cs_q) begin
        out_sh <= {out_sh[15:0], 1'b0};
      end
    end
  end
endmodule

// file: dv/adc_mode_decoder_tb.sv
`timescale 1ns/1ps
module adc_mode_decoder_tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cs_n, sclk, di, conv_n, sdo, test_mode;
  logic [7:0] pins_in = 8'h00;
  logic [7:0] pins_out, pins_oe, pat, w, pt;
  logic [95:0] chan_lvl = 96'h0;
  logic [11:0] zref = 12'h000;
  logic [11:0] mux_one, mux_two, em1, em2;
  logic [12:0] last;
  logic [31:0] rd;
  logic hold, pw;
  int fails = 0;
  int compares = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  adc_mode_decoder dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cs_n_i(cs_n),
    .sclk_i(sclk), .serial_instruction_in_i(di), .conv_n_i(conv_n), .serial_data_o(sdo),
    .analog_channel_pins_i(pins_in), .analog_channel_pins_o(pins_out),
    .analog_channel_pins_oe_o(pins_oe), .chan_level_i(chan_lvl),
    .zero_reference_input_i(zref), .mux_output_one_o(mux_one), .mux_output_two_o(mux_two),
    .test_mode_o(test_mode));

  serial_host host_u (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk), .di_o(di),
    .conv_n_o(conv_n), .sdo_i(sdo));

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic [3:0] adr, input logic we, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      stop_test();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask

  function automatic logic [11:0] lv(input int i);
    return chan_lvl[12*i +: 12];
  endfunction

  // Converter input one minus input two, swapped when the word asks for it
  function automatic logic [12:0] exp_code(input logic [7:0] x);
    int p, n, d;
    p = x[0] ? lv(x[3:1]) : lv({x[3:2], 1'b0});
    n = x[0] ? zref : lv({x[3:2], 1'b1});
    d = (!x[0] && x[5]) ? n - p : p - n;
    if (x[0] && d < 0) d = 0;
    return d[12:0];
  endfunction

  // First eight bits of a left-justified word with sign on: 13 bits, or 17 when wide
  function automatic logic [7:0] exp_top(input logic [12:0] c, input logic wd);
    return wd ? {{4{c[12]}}, c[12:9]} : c[12:5];
  endfunction

  task automatic mode_chk(input logic tm);
    wb(4'h4, 1'b0, 32'h0);
    chk("status_test", rd[9], tm);
    chk("test_mode", test_mode, tm);
    chk("pins_oe", pins_oe, {8{tm}});
    // Status word comes back in the frame after the read-status word
    host_u.frame(8'h30, 1'b1);
    host_u.frame(8'h30, 1'b1);
    chk("sdo_status", host_u.rx, {7'h00, tm});
  endtask

  task automatic seq4(input logic [7:0] a, b, c, d);
    host_u.frame(a, 1'b1);
    host_u.frame(b, 1'b1);
    host_u.frame(c, 1'b1);
    host_u.frame(d, 1'b1);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fails++;
    stop_test();
  end

  initial begin
    pat = 8'($urandom(32'h5C18878F));
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    wb(4'h4, 1'b0, 32'h0);
    chk("status_reset", {rd[9], rd[3:0]}, 32'h01);
    mode_chk(1'b0);
    pins_in <= 8'($urandom);
    chan_lvl <= {$urandom, $urandom, $urandom};
    zref <= 12'($urandom);
    wb(4'h0, 1'b1, {24'h0, pat});
    wb(4'h0, 1'b0, 32'h0);
    chk("ctrl", rd[7:0], pat);
    wb(4'h4, 1'b0, 32'h0);
    chk("pins_in", rd[31:24], pins_in);
    wb(4'hC, 1'b0, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Near misses: bit 0 low, then upper nibble not all high
    host_u.frame(8'hF0, 1'b1);
    host_u.frame(8'hB1, 1'b1);
    host_u.frame(8'hE1, 1'b0);
    last = exp_code(8'hE1);
    mode_chk(1'b0);
    for (int k = 0; k < 8; k++) begin
      host_u.frame({4'hF, k[2:0], 1'b1}, 1'b1);
      mode_chk(1'b1);
      chk("pins_drive", pins_out, pat);
      if (k == 3) begin
        seq4(8'h70, 8'hD0, 8'h50, 8'hF0);
        mode_chk(1'b1);
      end
      if (k == 7) begin
        // Second reset in mid-run stands in for a power cycle
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        last = 13'h0;
      end else begin
        seq4(8'h70, 8'h50, 8'hD0, 8'hF0);
      end
      mode_chk(1'b0);
    end
    // Configuration words change state but start no conversion
    for (int a = 0; a < 4; a++) begin
      host_u.frame(8'h70 | 8'(a), 1'b0);
      wb(4'h4, 1'b0, 32'h0);
      chk("acq", rd[2:1], a[1:0]);
    end
    for (int s = 0; s < 2; s++) begin
      host_u.frame(8'hB0 | 8'(s), 1'b0);
      wb(4'h4, 1'b0, 32'h0);
      chk("sign", rd[0], s[0]);
    end
    host_u.frame(8'h50, 1'b0);
    wb(4'h4, 1'b0, 32'h0);
    chk("powered", rd[4], 1'b1);
    wb(4'h8, 1'b0, 32'h0);
    chk("no_conv", rd[12:0], last);
    host_u.frame(8'hE1, 1'b0);
    last = exp_code(8'hE1);
    // This word asks for the 16-bit format
    pw = 1'b1;
    for (int t = 0; t < 24; t++) begin
      w = 8'($urandom) & 8'hEF;
      if (w[0]) w[5] = 1'b0;
      hold = (t % 5 == 4);
      if (t < 4) begin
        // Full-scale pairs and a zero reference at the top or the bottom of the scale
        chan_lvl <= {4{t[0] ? 24'h000FFF : 24'hFFF000}};
        zref <= t[1] ? 12'hFFF : 12'h000;
      end else begin
        chan_lvl <= {$urandom, $urandom, $urandom};
        zref <= 12'($urandom);
      end
      host_u.half = (t == 3) ? 8 : 4;
      // Each frame returns the previous conversion in that conversion's format
      pt = exp_top(last, pw);
      host_u.frame(w, hold);
      chk("sdo_result", host_u.rx, pt);
      if (!hold) begin
        last = exp_code(w);
        pw = w[6];
        em1 = w[0] ? lv(w[3:1]) : lv({w[3:2], 1'b0});
        em2 = w[0] ? zref : lv({w[3:2], 1'b1});
        chk("mux_one", mux_one, em1);
        chk("mux_two", mux_two, em2);
      end
      wb(4'h8, 1'b0, 32'h0);
      chk("result", rd[12:0], last);
      if (!hold && w[0]) chk("se_sign", rd[12], 1'b0);
    end
    stop_test();
  end
endmodule

// file: dv/serial_host.sv
`timescale 1ns/1ps
module serial_host (
  input wire logic clk_sys_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic di_o,
  output logic conv_n_o,
  input wire logic sdo_i
);
  // Half period of the link clock in system cycles; larger values give a slow host
  int half = 4;
  // Top eight bits of the word returned in the last frame
  logic [7:0] rx;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    di_o = 1'b0;
    conv_n_o = 1'b1;
  end
  // Link clock stands still between frames; every word gets its own select frame
  task automatic frame(input logic [7:0] w, input logic hold_conv);
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    conv_n_o <= hold_conv;
    repeat (half) @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++) begin
      di_o <= w[i];
      repeat (half) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      repeat (half) @(posedge clk_sys_i);
      // Sampled just before the falling edge that shifts the next bit out
      rx <= {rx[6:0], sdo_i};
      sclk_o <= 1'b0;
    end
    repeat (half) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    conv_n_o <= 1'b1;
    // Released line shows the inverse so a stale bit is never read as valid
    di_o <= ~w[7];
    repeat (12) @(posedge clk_sys_i);
  endtask
endmodule

// file: include/adc_mode_map.svh
`ifndef ADC_MODE_MAP_SVH
`define ADC_MODE_MAP_SVH

// Instruction word, bit 0 is the first bit shifted in
`define INSTR_BITS 5'h08
`define INS_ALL_MASK 8'hFF
`define INS_TEST_MASK 8'hF1
`define INS_TEST_VAL 8'hF1
`define INS_RESET_VAL 8'h70
`define INS_TEST_A_VAL 8'h50
`define INS_TEST_B_VAL 8'hD0
`define INS_USER_VAL 8'hF0
`define INS_POWER_UP_VAL 8'h50
`define INS_SIGN_MASK 8'hFE
`define INS_SIGN_VAL 8'hB0
`define INS_ACQ_MASK 8'hFC
`define INS_ACQ_VAL 8'h70
`define INS_STATUS_VAL 8'h30
`define INS_CONV_MASK 8'h10
`define INS_CONV_VAL 8'h00

// Conversion instruction fields
`define CF_SINGLE 0
`define CF_CHAN_LSB 1
`define CF_SWAP 5
`define CF_WIDE 6

// Output word
`define WORD_MSB 16
`define WORD_BITS 5'h11
`define LEN_NARROW 5'h0C
`define LEN_WIDE 5'h10
`define SIGN_BIT 12

// Status word fields
`define ST_SIGN 0
`define ST_ACQ_LSB 1
`define ST_WIDE 3
`define ST_POWERED 4
`define ST_TEST 9

// Register byte addresses
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RESULT 4'h8
`define CTRL_RESET 8'h00

`endif

// file: include/adc_mode_pkg.sv
package adc_mode_pkg;
  typedef enum logic [1:0] {REC_IDLE, REC_GOT_RESET, REC_GOT_FIRST, REC_GOT_SECOND} recovery_step_t;
  typedef logic [12:0] code_t;
  typedef logic [11:0] level_t;
endpackage
